// >>> hdl/icd_core.sv
// Execution unit for step, skip, interrupt-enable and computed branch ops
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module icd_core
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             global_irq_allow,
    output logic      [9:0]  pc_out,
    output logic             skip_next,
    output logic             busy
);

    // ****************************************************************
    // Storage and state
    // ****************************************************************
    logic [7:0]          file_r [icd_pkg::FILE_DEPTH];
    logic [7:0]          work_r, work_nxt;
    logic [7:0]          page_r, page_nxt;
    logic                zero_r, zero_nxt;
    logic                gie_r, gie_nxt;
    logic [9:0]          pc_r, pc_nxt;
    logic                skip_r, skip_nxt;
    logic                busy_r, busy_nxt;
    logic                ack_r, ack_nxt;
    logic [31:0]         dat_r, dat_nxt;
    logic [1:0]          cnt_r, cnt_nxt;
    icd_pkg::icd_state_t st_r, st_nxt;
    icd_pkg::icd_cmd_t   cmd_r, cmd_nxt;
    logic                fwe;
    logic [5:0]          fadr;
    logic [7:0]          fdat;
    logic [7:0]          step_res;
    logic                step_zero;
    logic                req;
    logic                wr_ok;

    assign req   = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_ok = req && wb_we_i && wb_sel_i[0];

    // Shared step arithmetic for all three step operations
    icd_step u_step
    (
        .operand (file_r[cmd_r.addr]),
        .down    (cmd_r.op == icd_pkg::ICD_OP_DEC),
        .result  (step_res),
        .is_zero (step_zero)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Bus writes are refused while an op runs so software cannot race it
    always_comb
    begin
        work_nxt = work_r;
        page_nxt = page_r;
        zero_nxt = zero_r;
        gie_nxt  = gie_r;
        pc_nxt   = pc_r;
        skip_nxt = 1'b0;
        cnt_nxt  = cnt_r;
        st_nxt   = st_r;
        cmd_nxt  = cmd_r;
        fwe      = 1'b0;
        fadr     = cmd_r.addr;
        fdat     = step_res;
        ack_nxt  = req;
        dat_nxt  = 32'h0000_0000;
        case (st_r)
            icd_pkg::ICD_IDLE:
            begin
                if (wr_ok && wb_adr_i == icd_pkg::OFF_CMD)
                begin
                    cmd_nxt = icd_pkg::icd_cmd_t'({
                        wb_dat_i[icd_pkg::CMD_OP_LSB+:4],
                        wb_dat_i[icd_pkg::CMD_ADDR_LSB+:6],
                        wb_dat_i[icd_pkg::CMD_DEST_BIT]});
                    st_nxt  = icd_pkg::ICD_EXEC;
                end
                else if (wr_ok && wb_adr_i == icd_pkg::OFF_WORK)
                    work_nxt = wb_dat_i[7:0];
                else if (wr_ok && wb_adr_i == icd_pkg::OFF_PAGE)
                    page_nxt = wb_dat_i[7:0];
                else if (wr_ok && wb_adr_i >= icd_pkg::OFF_FILE
                         && wb_adr_i[1:0] == 2'b00)
                begin
                    fwe  = 1'b1;
                    fadr = wb_adr_i[7:2] - 6'h20;
                    fdat = wb_dat_i[7:0];
                end
            end
            icd_pkg::ICD_EXEC:
            begin
                st_nxt  = icd_pkg::ICD_IDLE;
                cnt_nxt = icd_pkg::CYC_ONE;
                case (cmd_r.op)
                    icd_pkg::ICD_OP_DEC,
                    icd_pkg::ICD_OP_INC,
                    icd_pkg::ICD_OP_INCS:
                    begin
                        zero_nxt = step_zero;
                        if (cmd_r.dest)
                            fwe = 1'b1;
                        else
                            work_nxt = step_res;
                        if (cmd_r.op == icd_pkg::ICD_OP_INCS && step_zero)
                        begin
                            skip_nxt = 1'b1;
                            cnt_nxt  = icd_pkg::CYC_TWO;
                            st_nxt   = icd_pkg::ICD_WAIT;
                        end
                    end
                    icd_pkg::ICD_OP_IOFF: gie_nxt = 1'b0;
                    icd_pkg::ICD_OP_ION:  gie_nxt = 1'b1;
                    icd_pkg::ICD_OP_CBR:
                    begin
                        pc_nxt  = {page_r[1:0], work_r};
                        cnt_nxt = icd_pkg::CYC_TWO;
                        st_nxt  = icd_pkg::ICD_WAIT;
                    end
                    default: ;
                endcase
            end
            icd_pkg::ICD_WAIT:
                st_nxt = icd_pkg::ICD_IDLE;
            default:
                st_nxt = icd_pkg::ICD_IDLE;
        endcase
        // Read mux
        case (wb_adr_i)
            icd_pkg::OFF_CMD:    dat_nxt = {21'h0, cmd_r.dest,
                                            cmd_r.addr, cmd_r.op};
            icd_pkg::OFF_WORK:   dat_nxt = {24'h0, work_r};
            icd_pkg::OFF_PAGE:   dat_nxt = {24'h0, page_r};
            icd_pkg::OFF_STATUS: dat_nxt = {26'h0, cnt_r, busy_r,
                                            skip_r, gie_r, zero_r};
            icd_pkg::OFF_PC:     dat_nxt = {22'h0, pc_r};
            default:
                if (wb_adr_i >= icd_pkg::OFF_FILE)
                    dat_nxt = {24'h0, file_r[wb_adr_i[7:2] - 6'h20]};
                else
                    dat_nxt = 32'h0000_0000;
        endcase
        // Busy is registered so the output pin comes straight off a flop
        busy_nxt = (st_nxt != icd_pkg::ICD_IDLE);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Register file itself has no reset, like real core RAM
    always_ff @(posedge ref_clk)
    begin
        if (fwe)
            file_r[fadr] <= fdat;
    end

    // Control state
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            work_r <= icd_pkg::WORK_RST;
            page_r <= icd_pkg::PAGE_RST;
            zero_r <= 1'b0;
            gie_r  <= 1'b0;
            pc_r   <= icd_pkg::PC_RST;
            skip_r <= 1'b0;
            busy_r <= 1'b0;
            ack_r  <= 1'b0;
            dat_r  <= 32'h0000_0000;
            cnt_r  <= 2'h0;
            st_r   <= icd_pkg::ICD_IDLE;
            cmd_r  <= '0;
        end
        else
        begin
            work_r <= work_nxt;
            page_r <= page_nxt;
            zero_r <= zero_nxt;
            gie_r  <= gie_nxt;
            pc_r   <= pc_nxt;
            skip_r <= skip_nxt;
            busy_r <= busy_nxt;
            ack_r  <= ack_nxt;
            dat_r  <= dat_nxt;
            cnt_r  <= cnt_nxt;
            st_r   <= st_nxt;
            cmd_r  <= cmd_nxt;
        end
    end

    assign wb_ack_o         = ack_r;
    assign wb_dat_o         = dat_r;
    assign global_irq_allow = gie_r;
    assign pc_out           = pc_r;
    assign skip_next        = skip_r;
    assign busy             = busy_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_off;
        st_r == icd_pkg::ICD_EXEC && cmd_r.op == icd_pkg::ICD_OP_IOFF
        |=> !global_irq_allow;
    endproperty
    a_off: assert property (p_off) else $error("irq off failed");

    property p_on;
        st_r == icd_pkg::ICD_EXEC && cmd_r.op == icd_pkg::ICD_OP_ION
        |=> global_irq_allow;
    endproperty
    a_on: assert property (p_on) else $error("irq on failed");

    property p_cbr;
        st_r == icd_pkg::ICD_EXEC && cmd_r.op == icd_pkg::ICD_OP_CBR
        |=> pc_out == {$past(page_r[1:0]), $past(work_r)} && busy
            ##1 !busy;
    endproperty
    a_cbr: assert property (p_cbr) else $error("branch wrong");

    property p_skip;
        st_r == icd_pkg::ICD_EXEC && cmd_r.op == icd_pkg::ICD_OP_INCS
        && step_zero |=> skip_next && busy ##1 !busy;
    endproperty
    a_skip: assert property (p_skip) else $error("skip missing");

    // Only step ops; a branch stays busy whatever the addressed location holds
    property p_noskip;
        st_r == icd_pkg::ICD_EXEC && !step_zero
        && cmd_r.op inside {icd_pkg::ICD_OP_DEC, icd_pkg::ICD_OP_INC,
                            icd_pkg::ICD_OP_INCS}
        |=> !skip_next && !busy;
    endproperty
    a_noskip: assert property (p_noskip) else $error("bad skip");

    property p_dst0;
        st_r == icd_pkg::ICD_EXEC && !cmd_r.dest
        && cmd_r.op inside {icd_pkg::ICD_OP_DEC, icd_pkg::ICD_OP_INC}
        |=> work_r == $past(step_res) && zero_r == (work_r == 8'h00);
    endproperty
    a_dst0: assert property (p_dst0) else $error("work dest wrong");

    property p_wrap;
        st_r == icd_pkg::ICD_EXEC && cmd_r.op == icd_pkg::ICD_OP_INC
        && file_r[cmd_r.addr] == 8'hFF |=> zero_r;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");

    property p_dst1;
        st_r == icd_pkg::ICD_EXEC && cmd_r.dest
        && cmd_r.op == icd_pkg::ICD_OP_DEC
        |=> file_r[$past(cmd_r.addr)] == $past(step_res)
            && work_r == $past(work_r);
    endproperty
    a_dst1: assert property (p_dst1) else $error("file dest wrong");

    c_skip: cover property (skip_next);
    c_cbr:  cover property (st_r == icd_pkg::ICD_EXEC
                            && cmd_r.op == icd_pkg::ICD_OP_CBR);
    c_gie:  cover property (global_irq_allow ##1 !global_irq_allow);

endmodule

// >>> common/icd_pkg.sv
// Package for the increment/decrement, branch and interrupt-control unit
package icd_pkg;

    // ****************************************************************
    // Register map (Wishbone word addresses are byte offsets)
    // ****************************************************************
    localparam logic [7:0] OFF_CMD      = 8'h00;
    localparam logic [7:0] OFF_DATA     = 8'h04;
    localparam logic [7:0] OFF_WORK     = 8'h08;
    localparam logic [7:0] OFF_PAGE     = 8'h0C;
    localparam logic [7:0] OFF_STATUS   = 8'h10;
    localparam logic [7:0] OFF_PC       = 8'h14;
    localparam logic [7:0] OFF_FILE     = 8'h80;

    // Command word fields
    localparam int CMD_OP_LSB     = 0;
    localparam int CMD_ADDR_LSB   = 4;
    localparam int CMD_DEST_BIT   = 10;

    // Reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [9:0] PC_RST   = 10'h000;

    // Sizes
    localparam int FILE_DEPTH = 64;

    // Cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    // Operation codes
    typedef enum logic [3:0] {
        ICD_OP_NOP  = 4'h0,
        ICD_OP_DEC  = 4'h1,
        ICD_OP_INC  = 4'h2,
        ICD_OP_INCS = 4'h3,
        ICD_OP_IOFF = 4'h4,
        ICD_OP_ION  = 4'h5,
        ICD_OP_CBR  = 4'h6
    } icd_op_t;

    // Decoded instruction
    typedef struct packed {
        icd_op_t    op;
        logic [5:0] addr;
        logic       dest;
    } icd_cmd_t;

    // Execution states
    typedef enum logic [1:0] {
        ICD_IDLE = 2'b00,
        ICD_EXEC = 2'b01,
        ICD_WAIT = 2'b10
    } icd_state_t;

endpackage

// >>> hdl/icd_step.sv
// Eight-bit step unit: add or subtract one, with zero detect
`timescale 1ns/1ps
module icd_step
(
    input  wire logic [7:0] operand,
    input  wire logic       down,
    output logic      [7:0] result,
    output logic            is_zero
);

    // Wraps modulo 256 on purpose
    always_comb
    begin
        result  = down ? operand - 8'h01 : operand + 8'h01;
        is_zero = (result == 8'h00);
    end

endmodule

// >>> verif/tb_incdec_branch_intctl_ops.sv
// Self-checking bench for the step, skip, interrupt and branch unit
`timescale 1ns/1ps
module tb_incdec_branch_intctl_ops;
    logic                 ref_clk;
    logic                 sys_rst;
    logic                 wb_cyc_i;
    logic                 wb_stb_i;
    logic                 wb_we_i;
    logic [7:0]           wb_adr_i;
    logic [3:0]           wb_sel_i;
    logic [31:0]          wb_dat_i;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 global_irq_allow;
    logic [9:0]           pc_out;
    logic                 skip_next;
    logic                 busy;
    int                   n_fail;
    int                   checks;
    int                   skips;
    int                   s0;
    int                   n;
    logic [31:0]          q;
    logic [7:0]           v;
    logic [7:0]           w;
    logic [7:0]           r;
    logic [7:0]           pg;
    logic [5:0]           a;
    logic                 d;
    logic                 sk;
    icd_pkg::icd_op_t     op;
    logic [7:0]           corner [3] = '{8'h00, 8'h01, 8'hFF};
    icd_pkg::icd_op_t     ops [3] = '{icd_pkg::ICD_OP_INCS,
                                      icd_pkg::ICD_OP_DEC,
                                      icd_pkg::ICD_OP_INC};

    icd_core icd_core_inst
    (
        .ref_clk          (ref_clk),
        .sys_rst          (sys_rst),
        .wb_cyc_i         (wb_cyc_i),
        .wb_stb_i         (wb_stb_i),
        .wb_we_i          (wb_we_i),
        .wb_adr_i         (wb_adr_i),
        .wb_sel_i         (wb_sel_i),
        .wb_dat_i         (wb_dat_i),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .global_irq_allow (global_irq_allow),
        .pc_out           (pc_out),
        .skip_next        (skip_next),
        .busy             (busy)
    );

    // Free-running 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Count discard pulses; a one-cycle pulse is easy to miss by polling
    always @(posedge ref_clk)
    begin
        if (skip_next === 1'b1)
            skips = skips + 1;
    end

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic complete_run();
        $display("checks %0d  mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // Classic cycle: request held until ack is sampled, then released
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, input logic [3:0] sel);
        int k;
        k = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do
        begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1)
        begin
            n_fail++;
            complete_run();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Issue a command and count cycles until busy drops
    task automatic cmd(input icd_pkg::icd_op_t o, input logic [5:0] ad,
                       input logic de);
        bus(1'b1, icd_pkg::OFF_CMD, 32'(o)
            | (32'(ad) << icd_pkg::CMD_ADDR_LSB)
            | (32'(de) << icd_pkg::CMD_DEST_BIT), 4'hF);
        n = 0;
        while (busy !== 1'b0 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (busy !== 1'b0)
        begin
            n_fail++;
            complete_run();
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        sys_rst  = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        n_fail   = 0;
        checks   = 0;
        skips    = 0;
        void'($urandom(48907));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk("gie", 32'h0, 32'(global_irq_allow));
        bus(1'b0, icd_pkg::OFF_PC, 32'h0, 4'hF);
        chk("pc", 32'(icd_pkg::PC_RST), q);
        bus(1'b0, icd_pkg::OFF_DATA, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        // Corners first, then random steps; only 32 locations are mapped
        for (int i = 0; i < 60; i++)
        begin
            op = (i < 9) ? ops[i / 3]
                 : icd_pkg::icd_op_t'(4'($urandom_range(1, 3)));
            v  = (i < 9) ? corner[i % 3] : 8'($urandom);
            a  = 6'($urandom_range(0, 31));
            d  = 1'($urandom);
            w  = 8'($urandom);
            bus(1'b1, icd_pkg::OFF_FILE + {a, 2'b00}, 32'(v), 4'hF);
            bus(1'b1, icd_pkg::OFF_WORK, 32'(w), 4'hF);
            s0 = skips;
            cmd(op, a, d);
            r  = (op == icd_pkg::ICD_OP_DEC) ? v - 8'h01 : v + 8'h01;
            sk = (op == icd_pkg::ICD_OP_INCS) && (r == 8'h00);
            bus(1'b0, icd_pkg::OFF_FILE + {a, 2'b00}, 32'h0, 4'hF);
            chk("file", 32'(d ? r : v), q);
            bus(1'b0, icd_pkg::OFF_WORK, 32'h0, 4'hF);
            chk("work", 32'(d ? w : r), q);
            bus(1'b0, icd_pkg::OFF_STATUS, 32'h0, 4'hF);
            chk("zero", 32'(r == 8'h00), 32'(q[0]));
            chk("skips", 32'(sk), 32'(skips - s0));
            chk("cycles", sk ? 32'd2 : 32'd1, 32'(n));
        end
        // Enable then disable, each a single cycle
        cmd(icd_pkg::ICD_OP_ION, 6'h00, 1'b0);
        chk("gie on", 32'h1, 32'(global_irq_allow));
        chk("on cycles", 32'd1, 32'(n));
        cmd(icd_pkg::ICD_OP_IOFF, 6'h00, 1'b0);
        chk("gie off", 32'h0, 32'(global_irq_allow));
        chk("off cycles", 32'd1, 32'(n));
        // Lane 0 off drops a write; a no-op leaves the work value alone
        bus(1'b1, icd_pkg::OFF_WORK, 32'h0000_005A, 4'hF);
        bus(1'b1, icd_pkg::OFF_WORK, 32'h0000_00A5, 4'hE);
        bus(1'b0, icd_pkg::OFF_WORK, 32'h0, 4'hF);
        chk("sel0 off", 32'h0000_005A, q);
        cmd(icd_pkg::ICD_OP_NOP, 6'h00, 1'b0);
        chk("nop cycles", 32'd1, 32'(n));
        bus(1'b0, icd_pkg::OFF_WORK, 32'h0, 4'hF);
        chk("nop work", 32'h0000_005A, q);
        // Computed branch; page upper bits must be ignored
        for (int i = 0; i < 6; i++)
        begin
            pg = (i == 0) ? 8'hFF : 8'($urandom);
            w  = 8'($urandom);
            bus(1'b1, icd_pkg::OFF_PAGE, 32'(pg), 4'hF);
            bus(1'b1, icd_pkg::OFF_WORK, 32'(w), 4'hF);
            cmd(icd_pkg::ICD_OP_CBR, 6'h00, 1'b0);
            chk("pc out", 32'({pg[1:0], w}), 32'(pc_out));
            chk("br cycles", 32'd2, 32'(n));
            bus(1'b0, icd_pkg::OFF_PC, 32'h0, 4'hF);
            chk("pc reg", 32'({pg[1:0], w}), q);
        end
        complete_run();
    end
endmodule
